// [logic/dbd_decode.sv]
// decode and execute of decrement-file, decrement-skip-if-zero, unconditional jump
// assumes register file reads combinationally and fetch follows pc and flush
// Function
// - decode decrement-file, subtract one from file
// - destination bit picks accumulator or file
// - decrement-file sets zero flag on zero
// - skip variant decrements, routes result, no flags
// - zero result flushes prefetched word, two cycles
// - decode jump with eleven-bit literal, no flags
// - pc low from literal, high from latch
// - jump takes two cycles, refill stage
`default_nettype none
module dbd_decode
    import dbd_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rstn,
    input  wire logic            instr_valid,
    input  wire logic [IW_W-1:0] instr,
    input  wire logic [DW-1:0]   file_rdata,
    input  wire logic [DW-1:0]   pc_high_latch,
    input  wire logic [PCW-1:0]  pc_in,
    output logic [FAW-1:0]       file_raddr,
    output dbd_wb_t              wb_q,
    output dbd_flag_t            zflag_q,
    output logic                 pc_load_q,
    output logic [PCW-1:0]       pc_q,
    output logic                 flush,
    output logic                 busy
);
    dbd_state_t     state_q, state_d;
    dbd_wb_t        wb_d;
    dbd_flag_t      zflag_d;
    logic           pc_load_d;
    logic [PCW-1:0] pc_d;
    logic           is_dec, is_skip, is_jump;
    logic [DW-1:0]  dec_res;

    assign file_raddr = instr[FAW-1:0];

    always_comb begin
        is_dec  = instr_valid && (state_q == ST_RUN) && (instr[13:8] == OP_DEC_FILE);
        is_skip = instr_valid && (state_q == ST_RUN) && (instr[13:8] == OP_DEC_SKIP);
        // jump opcode, literal in low bits
        is_jump = instr_valid && (state_q == ST_RUN) && (instr[13:11] == OP_JUMP);
        dec_res = file_rdata - ONE_8;
    end

    always_comb begin
        wb_d      = '0;
        zflag_d   = '0;
        pc_load_d = 1'b0;
        pc_d      = pc_q;
        state_d   = state_q;
        flush     = 1'b0;
        case (state_q)
            ST_RUN: begin
                if (is_dec || is_skip) begin
                    wb_d.file_addr = instr[FAW-1:0];
                    wb_d.data      = dec_res;
                    wb_d.wr_file   = instr[DEST_BIT];
                    wb_d.wr_acc    = ~instr[DEST_BIT];
                end
                if (is_dec) begin
                    zflag_d.z_we  = 1'b1;
                    zflag_d.z_val = (dec_res == ZERO_8);
                end
                if (is_skip && (dec_res == ZERO_8)) begin
                    flush   = 1'b1;
                    state_d = ST_FLUSH;
                end
                if (is_jump) begin
                    pc_load_d = 1'b1;
                    pc_d      = {pc_high_latch[LATCH_LO_BIT+1:LATCH_LO_BIT], instr[JUMP_LIT_W-1:0]};
                    flush     = 1'b1;
                    state_d   = ST_FLUSH;
                end
                if (!is_jump) begin
                    pc_d = pc_in;
                end
            end
            ST_FLUSH: begin
                // executes as a no-operation
                state_d = ST_RUN;
                pc_d    = pc_in;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        busy = (state_q == ST_FLUSH);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q   <= ST_RUN;
            wb_q      <= '0;
            zflag_q   <= '0;
            pc_load_q <= 1'b0;
            pc_q      <= PC_RESET;
        end else begin
            state_q   <= state_d;
            wb_q      <= wb_d;
            zflag_q   <= zflag_d;
            pc_load_q <= pc_load_d;
            pc_q      <= pc_d;
        end
    end
endmodule
`default_nettype wire

// [logic/dbd_pkg.sv]
// package for the decrement-and-branch decode block
// assumes a core instruction clock and 14-bit instruction words
`default_nettype none
package dbd_pkg;
    localparam int IW_W = 14;
    localparam int DW   = 8;
    localparam int PCW  = 13;
    localparam int FAW  = 7;
    localparam logic [5:0]  OP_DEC_FILE  = 6'h03;
    localparam logic [5:0]  OP_DEC_SKIP  = 6'h0b;
    localparam logic [2:0]  OP_JUMP      = 3'h5;
    localparam int          DEST_BIT     = 7;
    localparam int          JUMP_LIT_W   = 11;
    localparam int          LATCH_LO_BIT = 3;
    localparam logic [7:0]  ONE_8        = 8'h01;
    localparam logic [7:0]  ZERO_8       = 8'h00;
    localparam logic [12:0] PC_RESET     = 13'h0000;
    localparam logic [1:0]  FLUSH_CYCLES = 2'h1;

    typedef struct packed {
        logic           wr_acc;
        logic           wr_file;
        logic [FAW-1:0] file_addr;
        logic [DW-1:0]  data;
    } dbd_wb_t;

    typedef struct packed {
        logic z_we;
        logic z_val;
    } dbd_flag_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FLUSH = 2'b01
    } dbd_state_t;
endpackage
`default_nettype wire

// [dv/dbd_decode_checker.sv]
// assertions on the dbd_decode ports
// assumes one clock and reset low
`default_nettype none
module dbd_decode_checker
    import dbd_pkg::*;
(
    input wire logic            clock, rstn, instr_valid, pc_load_q, flush, busy,
    input wire logic [IW_W-1:0] instr,
    input wire logic [DW-1:0]   file_rdata, pc_high_latch,
    input wire logic [PCW-1:0]  pc_q,
    input wire dbd_wb_t         wb_q,
    input wire dbd_flag_t       zflag_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // words offered while busy are never taken
    wire       tk = instr_valid & ~busy;
    wire       df = tk & instr[13:8] == OP_DEC_FILE;
    wire       ds = tk & instr[13:8] == OP_DEC_SKIP;
    wire       jp = tk & instr[13:11] == OP_JUMP;
    wire [7:0] r  = file_rdata - ONE_8;
    wire       rz = ds & r == ZERO_8;
    AST_DATA: assert property (df |=> wb_q.data == $past(r)) else $error("data");
    AST_DEST: assert property (df |=> {wb_q.wr_acc, wb_q.wr_file} == 2'b10 >> $past(instr[7])) else $error("d");
    AST_ZF: assert property (df |=> zflag_q == {1'b1, $past(r) == ZERO_8}) else $error("zf");
    AST_NOZ: assert property (ds | jp |=> !zflag_q.z_we) else $error("noz");
    AST_SKIP: assert property (rz |-> flush ##1 busy) else $error("skip");
    AST_RUN: assert property (ds & !rz |-> !flush ##1 !busy) else $error("run");
    AST_PC: assert property (jp |=> pc_q == {$past(pc_high_latch[4:3]), $past(instr[10:0])}) else $error("pc");
    AST_JMP: assert property (jp |-> flush ##1 busy && pc_load_q ##1 !busy) else $error("jmp");
    cover property (df);
    cover property (rz);
    cover property (jp);
endmodule
bind dbd_decode dbd_decode_checker dbd_decode_checker_i (.*);
`default_nettype wire

// [dv/test_dbd_decode.sv]
// bench for dbd_decode
// assumes the bench plays the register file
`default_nettype none
module test_dbd_decode;
    import dbd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, rstn = 0, instr_valid = 0, fl, pc_load_q, flush, busy;
    logic [13:0] instr = 14'h0000;
    logic [7:0]  file_rdata = 8'h00, pc_high_latch = 8'h13;
    logic [12:0] pc_in = 13'h0000, pc_q;
    logic [6:0]  file_raddr;
    dbd_wb_t     wb_q;
    dbd_flag_t   zflag_q;
    int          errors = 0, cmp_count = 0;
    always #20 clock = ~clock;
    dbd_decode dbd_decode_i (.*);
    task automatic c(string n, logic [16:0] e, g);
        cmp_count++;
        if (e !== g) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // flush is combinational: sample before the taking edge
    task automatic op(logic [13:0] i, logic [7:0] r);
        instr = i;
        file_rdata = r;
        instr_valid = 1;
        #1 fl = flush;
        @(negedge clock);
    endtask
    task automatic fin(string n);
        instr_valid = 0;
        @(negedge clock);
        $display("%s done", n);
    endtask
    task automatic t_dec;
        pc_in = 13'h0123;
        op(14'h0385, 8'h01);
        c("dec", 11'h700, {zflag_q, wb_q.wr_file, wb_q.data});
        c("addr", 14'h0285, {file_raddr, wb_q.file_addr});
        c("pc", 13'h0123, pc_q);
        op(14'h0305, 8'h00);
        c("wrap", 11'h5ff, {zflag_q, wb_q.wr_acc, wb_q.data});
        fin("dec");
    endtask
    task automatic t_skp;
        op(14'h0b85, 8'h01);
        c("skp", 12'he00, {fl, busy, wb_q.wr_file, zflag_q.z_we, wb_q.data});
        op(14'h0385, 8'h09);
        c("ign", 2'b00, {wb_q.wr_acc, wb_q.wr_file});
        op(14'h0b05, 8'h03);
        c("one", 11'h102, {fl, busy, wb_q.wr_acc, wb_q.data});
        fin("skp");
    endtask
    task automatic t_jmp;
        op(14'h2fff, 8'h00);
        c("jmp", 17'h1_d7ff, {fl, busy, pc_load_q, zflag_q.z_we, pc_q});
        op(14'h2fff, 8'h00);
        c("ign", 3'h0, {fl, busy, pc_load_q});
        op(14'h2005, 8'h00);
        c("call", 3'h0, {fl, busy, pc_load_q});
        fin("jmp");
    endtask
    // reset dropped mid-jump, first word right at release
    task automatic t_rst;
        op(14'h2805, 8'h00);
        rstn = 0;
        #1 c("rst", 15'h0000, {busy, pc_load_q, pc_q});
        @(negedge clock);
        rstn = 1;
        op(14'h0305, 8'h10);
        c("post", 11'h50f, {zflag_q, wb_q.wr_acc, wb_q.data});
        fin("rst");
    endtask
    task automatic end_of_test;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clock);
        rstn = 1;
        t_dec;
        t_skp;
        t_jmp;
        t_rst;
        end_of_test;
    end
endmodule
`default_nettype wire
